// ### dv/req_model.sv
// requester model: sends request frames byte by byte, sinks replies
// assumes the engine samples all signals on the rising edge of clk_i
`timescale 1ns/1ps
module req_model (
   input  wire logic clk_i,
   input  wire logic rx_ready_i,
   output logic       rx_valid_o   = 1'b0,
   output logic [7:0] rx_data_o    = 8'h00,
   output logic       rx_last_o    = 1'b0,
   output logic       rx_unicast_o = 1'b0,
   output logic [7:0] rx_ep_o      = 8'h00,
   output logic       tx_ready_o   = 1'b0
);
   logic [31:0] seed = 32'h3DD5FF64;
   logic        stall = 1'b0;

   // with stall set the sink refuses bytes on a pseudo random pattern
   always @(posedge clk_i) begin
      seed <= {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      tx_ready_o <= stall ? seed[3] : 1'b1;
   end

   // each byte is held until the engine is seen ready at an edge
   task automatic send(input logic [7:0] b[$], input logic uni,
                       input logic [7:0] ep);
      int n;
      foreach (b[i]) begin
         rx_valid_o <= 1'b1;
         rx_data_o <= b[i];
         rx_last_o <= (i == b.size() - 1);
         rx_unicast_o <= uni;
         rx_ep_o <= ep;
         n = 0;
         do begin
            @(posedge clk_i);
            n++;
         end while (!rx_ready_i && n < 400);
      end
      rx_valid_o <= 1'b0;
      rx_last_o <= 1'b0;
      // released data line shows the inverse, never a stale byte
      rx_data_o <= ~rx_data_o;
      // let an edge pass so a following frame never reassigns in this step
      @(posedge clk_i);
   endtask : send
endmodule : req_model

// ### dv/tb_top.sv
// self-checking bench of the flash command engine
// assumes the requester model and a 200 MHz mclk_i
`timescale 1ns/1ps
module tb_top import fstore_pkg::*; ;
   logic        mclk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        rx_valid_i, rx_last_i, rx_unicast_i, rx_ready_o;
   logic        tx_valid_o, tx_last_o, tx_ready_i, irq_o;
   logic [7:0]  rx_data_i, rx_ep_i, tx_data_o, tx_ep_o;
   logic [7:0]  addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0, rdata_o;
   logic        wr_i = 1'b0, rd_i = 1'b0;
   int          bad_count = 0, compares = 0;
   logic [16:0] expq[$];
   logic [7:0]  dq[$];
   logic [31:0] lf = 32'h3DD5FF64;

   initial forever #2.5 mclk_i = ~mclk_i;

   memory_write_reply_and_read_cmd #(.NBLK(4), .BLKSZ(64))
      memory_write_reply_and_read_cmd_inst (.*);
   req_model req_model_inst (.clk_i(mclk_i), .rx_ready_i(rx_ready_o),
      .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
      .rx_last_o(rx_last_i), .rx_unicast_o(rx_unicast_i),
      .rx_ep_o(rx_ep_i), .tx_ready_o(tx_ready_i));

   function automatic logic [7:0] rnd();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf[7:0];
   endfunction : rnd

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen,
                  exp);
      end
   endtask : check

   task automatic give_verdict();
      $display("mismatches %0d, comparisons %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 check(rdata_o, e);
   endtask : reg_rd

   // one request; when ex is set the expected reply bytes go to the queue first
   task automatic xfer(input logic [7:0] c, input logic [15:0] blk, off,
      cnt, input logic [7:0] rc, input logic err, input logic [15:0] rcnt,
      input logic uni, input logic ex);
      logic [7:0] fr[$];
      logic [7:0] r[$];
      logic [7:0] ep;
      ep = rnd();
      fr = {c, 8'h00, blk[15:8], blk[7:0], off[15:8], off[7:0], cnt[15:8],
            cnt[7:0]};
      r = {rc, 8'(err), blk[15:8], blk[7:0], off[15:8], off[7:0],
           rcnt[15:8], rcnt[7:0]};
      if (c == CMD_FETCH)
         r = {r, dq};
      else
         fr = {fr, dq};
      if (ex)
         foreach (r[i]) expq.push_back({i == r.size() - 1, ep, r[i]});
      req_model_inst.send(fr, uni, ep);
   endtask : xfer

   task automatic drain();
      int n;
      n = 0;
      while (expq.size() != 0 && n < 2000) begin
         @(posedge mclk_i);
         n++;
      end
      repeat (4) @(posedge mclk_i);
      check(expq.size(), 0);
   endtask : drain

   always @(posedge mclk_i) begin
      if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
         if (expq.size() == 0)
            check(tx_valid_o, 1'b0);
         else
            check({tx_last_o, tx_ep_o, tx_data_o}, expq.pop_front());
      end
   end

   initial begin
      #200000;
      bad_count++;
      give_verdict();
   end

   initial begin
      repeat (16) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      reg_rd(REG_CTRL, 32'h1);
      reg_wr(REG_IRQ_EN, 32'h7);
      reg_rd(REG_IRQ_EN, 32'h7);
      reg_rd(8'h14, 32'h0);
      dq = {rnd(), rnd()};
      xfer(CMD_PROG, 16'h1, 16'h0, 16'h2, RSP_PROG, 0, 0, 1, 1);
      xfer(CMD_FETCH, 16'h1, 16'h0, 16'h2, RSP_FETCH, 0, 2, 1, 1);
      dq = {8'h0F};
      xfer(CMD_ERPROG, 16'h1, 16'h1, 16'h1, RSP_ERPROG, 0, 0, 1, 1);
      req_model_inst.stall = 1'b1;
      dq = {ERASED_BYTE, 8'h0F};
      xfer(CMD_FETCH, 16'h1, 16'h0, 16'h2, RSP_FETCH, 0, 2, 1, 1);
      dq = {ERASED_BYTE};
      xfer(CMD_FETCH, 16'h3, 16'h3F, 16'h1, RSP_FETCH, 0, 1, 1, 1);
      drain();
      reg_wr(REG_IRQ_CLR, 32'h7);
      dq = {};
      xfer(CMD_FETCH, 16'h1, 16'h3F, 16'h2, RSP_FETCH, 1, 0, 1, 1);
      drain();
      reg_rd(REG_IRQ_STAT, 32'h3);
      // idle state code with the error of the last reply in bit 4
      reg_rd(REG_STATE, 32'h11);
      reg_wr(REG_IRQ_CLR, 32'h7);
      xfer(CMD_FETCH, 16'h1, 16'h0, 16'h1, RSP_FETCH, 0, 1, 0, 0);
      drain();
      reg_rd(REG_IRQ_STAT, 32'h4);
      check(irq_o, 1'b1);
      reg_wr(REG_IRQ_CLR, 32'h4);
      repeat (3) @(posedge mclk_i);
      check(irq_o, 1'b0);
      reg_wr(REG_CTRL, 32'h0);
      xfer(CMD_FETCH, 16'h1, 16'h0, 16'h1, RSP_FETCH, 0, 1, 1, 0);
      drain();
      give_verdict();
   end
endmodule : tb_top

// ### src/flash_store.sv
// byte store that behaves like flash: program only clears bits,
// erase sets a whole block to all ones in one cycle
// assumes block count and block size are powers of two
`timescale 1ns/1ps
module flash_store import fstore_pkg::*; #(
   parameter int NBLK  = 4,
   parameter int BLKSZ = 64
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   mem_if.store     m
);
   localparam int OW    = $clog2(BLKSZ);
   localparam int DEPTH = NBLK * BLKSZ;
   localparam int AW    = $clog2(DEPTH);

   logic [7:0] cells [DEPTH];

   assign m.rdata = cells[m.raddr];

   for (genvar i = 0; i < DEPTH; i++) begin : g_cell
      localparam logic [AW-1:0] A = AW'(i);
      logic [7:0] cell_ff;
      logic [7:0] nxt_cell;
      always_comb begin
         nxt_cell = cell_ff;
         if (m.erase && m.waddr[AW-1:OW] == A[AW-1:OW]) begin
            nxt_cell = ERASED_BYTE;
         end else if (m.wr && m.waddr == A) begin
            // a program can only pull bits low
            nxt_cell = cell_ff & m.wdata;
         end
      end
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            cell_ff <= ERASED_BYTE;
         end else begin
            cell_ff <= nxt_cell;
         end
      end
      assign cells[i] = cell_ff;
   end
endmodule : flash_store

// ### src/frame_parser.sv
// splits an accepted request frame into header word, payload bytes
// and an end marker; all outputs are registered
// assumes unicast flag and endpoint are steady across a frame
`timescale 1ns/1ps
module frame_parser import fstore_pkg::*; (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       rx_valid_i,
   input  wire logic [7:0] rx_data_i,
   input  wire logic       rx_last_i,
   input  wire logic       rx_unicast_i,
   input  wire logic [7:0] rx_ep_i,
   input  wire logic       take_i,
   hdr_if.prod             h
);
   logic [15:0] idx_ff,  nxt_idx;
   logic [63:0] hdr_ff,  nxt_hdr;
   logic        hstb_ff, nxt_hstb;
   logic        pstb_ff, nxt_pstb;
   logic        estb_ff, nxt_estb;
   logic        uni_ff,  nxt_uni;
   logic [7:0]  pdat_ff, nxt_pdat;
   logic [7:0]  ep_ff,   nxt_ep;
   logic [15:0] pn_ff,   nxt_pn;
   logic [15:0] len_ff,  nxt_len;
   logic        acc;

   assign acc = rx_valid_i && take_i;

   always_comb begin
      nxt_idx  = idx_ff;
      nxt_hdr  = hdr_ff;
      nxt_hstb = 1'b0;
      nxt_pstb = 1'b0;
      nxt_estb = 1'b0;
      nxt_uni  = uni_ff;
      nxt_ep   = ep_ff;
      nxt_pdat = pdat_ff;
      nxt_pn   = pn_ff;
      nxt_len  = len_ff;
      if (acc) begin
         nxt_uni = rx_unicast_i;
         nxt_ep  = rx_ep_i;
         if (idx_ff < 16'(HDR_BYTES)) begin
            nxt_hdr  = {hdr_ff[HDR_W-9:0], rx_data_i};
            nxt_hstb = idx_ff == 16'(HDR_BYTES - 1);
         end else begin
            nxt_pstb = 1'b1;
            nxt_pdat = rx_data_i;
            nxt_pn   = idx_ff - 16'(HDR_BYTES);
         end
         if (rx_last_i) begin
            nxt_estb = 1'b1;
            nxt_len  = idx_ff + 16'h0001;
            nxt_idx  = 16'h0000;
         end else if (idx_ff != 16'hFFFF) begin
            nxt_idx = idx_ff + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         idx_ff  <= 16'h0000;
         hdr_ff  <= 64'h0;
         hstb_ff <= 1'b0;
         pstb_ff <= 1'b0;
         estb_ff <= 1'b0;
         uni_ff  <= 1'b0;
         ep_ff   <= 8'h00;
         pdat_ff <= 8'h00;
         pn_ff   <= 16'h0000;
         len_ff  <= 16'h0000;
      end else begin
         idx_ff  <= nxt_idx;
         hdr_ff  <= nxt_hdr;
         hstb_ff <= nxt_hstb;
         pstb_ff <= nxt_pstb;
         estb_ff <= nxt_estb;
         uni_ff  <= nxt_uni;
         ep_ff   <= nxt_ep;
         pdat_ff <= nxt_pdat;
         pn_ff   <= nxt_pn;
         len_ff  <= nxt_len;
      end
   end

   assign h.hdr      = hdr_ff;
   assign h.hdr_stb  = hstb_ff;
   assign h.pay_stb  = pstb_ff;
   assign h.pay_data = pdat_ff;
   assign h.pay_n    = pn_ff;
   assign h.end_stb  = estb_ff;
   assign h.end_len  = len_ff;
   assign h.uni      = uni_ff;
   assign h.ep       = ep_ff;
endmodule : frame_parser

// ### src/fstore_if.sv
// carriers between the command engine, its frame parser and its store
// assumes all three share one clock
`timescale 1ns/1ps
interface hdr_if;
   logic [63:0] hdr;
   logic        hdr_stb;
   logic        pay_stb;
   logic [7:0]  pay_data;
   logic [15:0] pay_n;
   logic        end_stb;
   logic [15:0] end_len;
   logic        uni;
   logic [7:0]  ep;
   modport prod (output hdr, hdr_stb, pay_stb, pay_data, pay_n,
                 output end_stb, end_len, uni, ep);
   modport cons (input hdr, hdr_stb, pay_stb, pay_data, pay_n,
                 input end_stb, end_len, uni, ep);
endinterface : hdr_if

interface mem_if #(parameter int AW = 8);
   logic          erase;
   logic          wr;
   logic [AW-1:0] waddr;
   logic [7:0]    wdata;
   logic [AW-1:0] raddr;
   logic [7:0]    rdata;
   modport store (input erase, wr, waddr, wdata, raddr, output rdata);
   modport user  (output erase, wr, waddr, wdata, raddr, input rdata);
endinterface : mem_if

// ### src/fstore_pkg.sv
// constants, register map and state codes of the flash command engine
// assumes a byte-wide frame stream and a plain register port
package fstore_pkg;
   // command and reply codes
   localparam logic [7:0] CMD_PROG    = 8'h02;
   localparam logic [7:0] CMD_ERPROG  = 8'h03;
   localparam logic [7:0] CMD_FETCH   = 8'h04;
   localparam logic [7:0] RSP_PROG    = 8'h82;
   localparam logic [7:0] RSP_ERPROG  = 8'h83;
   localparam logic [7:0] RSP_FETCH   = 8'h84;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   // header layout, byte 0 in the top lane, fields msb first
   localparam int HDR_BYTES = 8;
   localparam int HDR_W     = 64;
   localparam int F_CMD     = 56;
   localparam int F_FLG     = 48;
   localparam int F_BLK     = 32;
   localparam int F_OFF     = 16;
   localparam int F_CNT     = 0;
   localparam int ERR_BIT   = 0;
   // register offsets
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STATE    = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_EN   = 8'h0C;
   localparam logic [7:0] REG_IRQ_CLR  = 8'h10;
   localparam logic       CTRL_EN_RST  = 1'b1;
   localparam int ST_ERR_BIT = 4;
   // interrupt status bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR  = 1;
   localparam int IRQ_DROP = 2;
   localparam int IRQ_W    = 3;
   typedef enum logic [2:0] {
      S_RX  = 3'h1,
      S_TX  = 3'h2,
      S_END = 3'h4
   } state_t;
endpackage : fstore_pkg

// ### src/memory_write_reply_and_read_cmd.sv
// command engine for the general flash store: programs blocks from
// request frames and returns program and fetch replies
// assumes request and reply streams and registers share mclk_i
// Contract
// - program replies 0x82, clear-then-program replies 0x83
// - result bit zero one on failure
// - reply echoes request block index
// - program replies carry zero count, no payload
// - reply only unicast, to source endpoint
// - fetch reply uses code 0x84
// - fetch reply count equals appended bytes
// - fetch payload is block bytes from offset
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
module memory_write_reply_and_read_cmd import fstore_pkg::*; #(
   parameter int NBLK  = 4,
   parameter int BLKSZ = 64
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic        rx_valid_i,
   input  wire logic [7:0]  rx_data_i,
   input  wire logic        rx_last_i,
   input  wire logic        rx_unicast_i,
   input  wire logic [7:0]  rx_ep_i,
   output logic             rx_ready_o,
   output logic             tx_valid_o,
   output logic [7:0]       tx_data_o,
   output logic             tx_last_o,
   output logic [7:0]       tx_ep_o,
   input  wire logic        tx_ready_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic [31:0]      rdata_o,
   output logic             irq_o
);
   localparam int BW = $clog2(NBLK);
   localparam int OW = $clog2(BLKSZ);
   localparam int AW = BW + OW;

   if (NBLK < 2 || BLKSZ < 2 || BLKSZ > 4096 || NBLK > 65536 ||
       (1 << BW) != NBLK || (1 << OW) != BLKSZ) begin : g_bad_param
      $error("block count and size must be powers of two in range");
   end

   logic rs1_ff;
   logic rst_n;
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rs1_ff <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rs1_ff <= 1'b1;
         rst_n  <= rs1_ff;
      end
   end

   hdr_if h ();
   mem_if #(.AW(AW)) m ();

   logic rx_ready_ff;

   frame_parser u_parse (
      .clk_i        (mclk_i),
      .rst_n_i      (rst_n),
      .rx_valid_i   (rx_valid_i),
      .rx_data_i    (rx_data_i),
      .rx_last_i    (rx_last_i),
      .rx_unicast_i (rx_unicast_i),
      .rx_ep_i      (rx_ep_i),
      .take_i       (rx_ready_ff),
      .h            (h)
   );

   flash_store #(.NBLK(NBLK), .BLKSZ(BLKSZ)) u_store (
      .clk_i   (mclk_i),
      .rst_n_i (rst_n),
      .m       (m)
   );

   function automatic logic in_block(input logic [15:0] blk,
                                     input logic [15:0] off,
                                     input logic [15:0] cnt);
      in_block = (blk < 16'(NBLK)) &&
                 ({1'b0, off} + {1'b0, cnt} <= 17'(BLKSZ));
   endfunction : in_block

   // request fields; option flags are not looked at
   logic [7:0]  q_cmd;
   logic [15:0] q_blk, q_off, q_cnt;
   logic        q_prog, q_fetch, q_rng, ctrl_en_ff;
   assign q_cmd   = h.hdr[F_CMD +: 8];
   assign q_blk   = h.hdr[F_BLK +: 16];
   assign q_off   = h.hdr[F_OFF +: 16];
   assign q_cnt   = h.hdr[F_CNT +: 16];
   assign q_prog  = q_cmd == CMD_PROG || q_cmd == CMD_ERPROG;
   assign q_fetch = q_cmd == CMD_FETCH;
   assign q_rng   = in_block(q_blk, q_off, q_cnt);

   // program path: bytes go to the store as they arrive
   logic prog_act_ff, nxt_prog_act;
   always_comb begin
      nxt_prog_act = prog_act_ff;
      m.erase      = 1'b0;
      m.wr         = 1'b0;
      if (h.hdr_stb) begin
         nxt_prog_act = q_prog && q_rng && h.uni && ctrl_en_ff;
         m.erase      = nxt_prog_act && q_cmd == CMD_ERPROG;
      end
      // surplus payload beyond the count is never written
      if (h.pay_stb && prog_act_ff && h.pay_n < q_cnt) begin
         m.wr = 1'b1;
      end
      if (h.end_stb) begin
         nxt_prog_act = 1'b0;
      end
   end
   assign m.waddr = {q_blk[BW-1:0], OW'(q_off + h.pay_n)};
   assign m.wdata = h.pay_data;

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         prog_act_ff <= 1'b0;
      end else begin
         prog_act_ff <= nxt_prog_act;
      end
   end

   // frame end decision
   logic       good, len_ok, exp_err;
   logic [7:0] exp_code;
   logic [7:0] exp_flags;
   assign len_ok = {1'b0, h.end_len} == 17'(q_cnt) + 17'(HDR_BYTES);
   assign good   = h.end_len >= 16'(HDR_BYTES) && h.uni && ctrl_en_ff &&
                   (q_prog || q_fetch);
   assign exp_err = !q_rng || (q_prog && !len_ok);
   always_comb begin
      unique case (q_cmd)
         CMD_PROG:   exp_code = RSP_PROG;
         CMD_ERPROG: exp_code = RSP_ERPROG;
         default:    exp_code = RSP_FETCH;
      endcase
      exp_flags          = 8'h00;
      exp_flags[ERR_BIT] = exp_err;
   end

   // reply sender
   state_t      state_ff,  nxt_state;
   logic [15:0] pos_ff,    nxt_pos;
   logic        tx_valid_ff, nxt_tx_valid;
   logic [7:0]  tx_data_ff,  nxt_tx_data;
   logic        tx_last_ff,  nxt_tx_last;
   logic [7:0]  tx_ep_ff,    nxt_tx_ep;
   logic        nxt_rx_ready;
   logic [63:0] sh_ff,     nxt_sh;
   logic [7:0]  code_ff,   nxt_code;
   logic [15:0] blk_ff,    nxt_blk;
   logic [15:0] off_ff,    nxt_off;
   logic [15:0] dcnt_ff,   nxt_dcnt;
   logic        err_ff,    nxt_err;
   logic [15:0] load_pos;
   logic        ev_done, ev_err, ev_drop;

   assign load_pos = tx_valid_ff ? pos_ff + 16'h0001 : 16'h0000;
   assign m.raddr  = {blk_ff[BW-1:0],
                      OW'(off_ff + load_pos - 16'(HDR_BYTES))};

   always_comb begin
      nxt_state    = state_ff;
      nxt_pos      = pos_ff;
      nxt_tx_valid = tx_valid_ff;
      nxt_tx_data  = tx_data_ff;
      nxt_tx_last  = tx_last_ff;
      nxt_tx_ep    = tx_ep_ff;
      nxt_rx_ready = rx_ready_ff;
      nxt_sh       = sh_ff;
      nxt_code     = code_ff;
      nxt_blk      = blk_ff;
      nxt_off      = off_ff;
      nxt_dcnt     = dcnt_ff;
      nxt_err      = err_ff;
      ev_done      = 1'b0;
      ev_err       = 1'b0;
      ev_drop      = 1'b0;
      unique case (state_ff)
         S_RX: begin
            // stop taking bytes once a frame is complete
            if (rx_valid_i && rx_ready_ff && rx_last_i) begin
               nxt_rx_ready = 1'b0;
            end
            if (h.end_stb) begin
               if (good) begin
                  nxt_state = S_TX;
                  nxt_code  = exp_code;
                  nxt_blk   = q_blk;
                  nxt_off   = q_off;
                  nxt_err   = exp_err;
                  nxt_tx_ep = h.ep;
                  // fetch payload in the request is ignored
                  nxt_dcnt  = (q_fetch && q_rng) ? q_cnt : 16'h0000;
                  nxt_sh    = {exp_code, exp_flags, q_blk, q_off,
                               nxt_dcnt};
               end else begin
                  ev_drop      = 1'b1;
                  nxt_rx_ready = 1'b1;
               end
            end
         end
         S_TX: begin
            if (!tx_valid_ff || tx_ready_i) begin
               nxt_tx_valid = 1'b1;
               nxt_pos      = load_pos;
               if (load_pos < 16'(HDR_BYTES)) begin
                  nxt_tx_data = sh_ff[F_CMD +: 8];
                  nxt_sh      = {sh_ff[HDR_W-9:0], 8'h00};
               end else begin
                  nxt_tx_data = m.rdata;
               end
               nxt_tx_last = load_pos == 16'(HDR_BYTES - 1) + dcnt_ff;
               if (nxt_tx_last) begin
                  nxt_state = S_END;
               end
            end
         end
         S_END: begin
            if (tx_ready_i) begin
               nxt_tx_valid = 1'b0;
               nxt_tx_last  = 1'b0;
               nxt_rx_ready = 1'b1;
               nxt_state    = S_RX;
               ev_done      = 1'b1;
               ev_err       = err_ff;
            end
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_ff    <= S_RX;
         pos_ff      <= 16'h0000;
         tx_valid_ff <= 1'b0;
         tx_data_ff  <= 8'h00;
         tx_last_ff  <= 1'b0;
         tx_ep_ff    <= 8'h00;
         // ready from reset, or no first frame could ever enter
         rx_ready_ff <= 1'b1;
         sh_ff       <= 64'h0;
         code_ff     <= 8'h00;
         blk_ff      <= 16'h0000;
         off_ff      <= 16'h0000;
         dcnt_ff     <= 16'h0000;
         err_ff      <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         pos_ff      <= nxt_pos;
         tx_valid_ff <= nxt_tx_valid;
         tx_data_ff  <= nxt_tx_data;
         tx_last_ff  <= nxt_tx_last;
         tx_ep_ff    <= nxt_tx_ep;
         rx_ready_ff <= nxt_rx_ready;
         sh_ff       <= nxt_sh;
         code_ff     <= nxt_code;
         blk_ff      <= nxt_blk;
         off_ff      <= nxt_off;
         dcnt_ff     <= nxt_dcnt;
         err_ff      <= nxt_err;
      end
   end

   // register port and interrupts
   logic [IRQ_W-1:0] stat_ff, nxt_stat, en_ff, nxt_en, ev;
   logic             nxt_ctrl_en, irq_ff, nxt_irq;
   logic [31:0]      rdata_ff, nxt_rdata;
   assign ev = {ev_drop, ev_err, ev_done};
   always_comb begin
      nxt_ctrl_en = ctrl_en_ff;
      nxt_en      = en_ff;
      nxt_stat    = stat_ff;
      nxt_rdata   = 32'h0;
      if (wr_i && addr_i == REG_CTRL) begin
         nxt_ctrl_en = wdata_i[0];
      end
      if (wr_i && addr_i == REG_IRQ_EN) begin
         nxt_en = wdata_i[IRQ_W-1:0];
      end
      if (wr_i && addr_i == REG_IRQ_CLR) begin
         nxt_stat = stat_ff & ~wdata_i[IRQ_W-1:0];
      end
      // a new event beats a clear in the same cycle
      nxt_stat = nxt_stat | ev;
      nxt_irq  = |(nxt_stat & nxt_en);
      if (rd_i) begin
         unique case (addr_i)
            REG_CTRL:     nxt_rdata = 32'(ctrl_en_ff);
            REG_STATE:    nxt_rdata = 32'(state_ff) |
                                      (32'(err_ff) << ST_ERR_BIT);
            REG_IRQ_STAT: nxt_rdata = 32'(stat_ff);
            REG_IRQ_EN:   nxt_rdata = 32'(en_ff);
            default:      nxt_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_en_ff <= CTRL_EN_RST;
         en_ff      <= '0;
         stat_ff    <= '0;
         irq_ff     <= 1'b0;
         rdata_ff   <= 32'h0;
      end else begin
         ctrl_en_ff <= nxt_ctrl_en;
         en_ff      <= nxt_en;
         stat_ff    <= nxt_stat;
         irq_ff     <= nxt_irq;
         rdata_ff   <= nxt_rdata;
      end
   end

   assign rx_ready_o = rx_ready_ff;
   assign tx_valid_o = tx_valid_ff;
   assign tx_data_o  = tx_data_ff;
   assign tx_last_o  = tx_last_ff;
   assign tx_ep_o    = tx_ep_ff;
   assign rdata_o    = rdata_ff;
   assign irq_o      = irq_ff;

   // checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n);

   logic fetch_start;
   assign fetch_start = state_ff == S_RX && h.end_stb && good && q_fetch;

   sequence s_start;
      state_ff == S_RX && h.end_stb && good;
   endsequence
   sequence s_first_byte;
      tx_valid_ff && pos_ff == 16'h0000;
   endsequence

   a_code_map: assert property (
      s_start |-> ##2 s_first_byte ##0 tx_data_ff == $past(exp_code, 2))
      else $error("reply code does not match request");
   a_fetch_code: assert property (
      fetch_start |-> ##2 tx_data_ff == RSP_FETCH)
      else $error("fetch reply code wrong");
   a_flag_bits: assert property (
      tx_valid_ff && pos_ff == 16'h0001 |->
         tx_data_ff[7:1] == 7'h00 && tx_data_ff[ERR_BIT] == err_ff)
      else $error("result flags byte wrong");
   a_block_echo: assert property (
      tx_valid_ff && pos_ff == 16'h0002 && tx_ready_i |=>
         tx_data_ff == blk_ff[7:0] && pos_ff == 16'h0003)
      else $error("block index not echoed");
   a_prog_empty: assert property (
      tx_valid_ff && tx_last_ff && code_ff != RSP_FETCH |->
         pos_ff == 16'(HDR_BYTES - 1))
      else $error("program reply carries payload");
   a_drop_silent: assert property (
      state_ff == S_RX && h.end_stb && !h.uni |=> !tx_valid_ff [*3])
      else $error("reply sent for non-unicast request");
   a_count_match: assert property (
      tx_valid_ff && tx_last_ff |->
         pos_ff == 16'(HDR_BYTES - 1) + dcnt_ff)
      else $error("payload length differs from count");
   a_fetch_data: assert property (
      state_ff == S_TX && (!tx_valid_ff || tx_ready_i) &&
      load_pos >= 16'(HDR_BYTES) |=> tx_data_ff == $past(m.rdata))
      else $error("fetch payload not taken from store");
   a_range_err: assert property (
      fetch_start && !q_rng |=> err_ff && dcnt_ff == 16'h0000)
      else $error("out-of-block fetch not flagged");
   a_hold_reply: assert property (
      tx_valid_ff && !tx_ready_i |=> tx_valid_ff && $stable(tx_data_ff))
      else $error("reply byte changed while stalled");
endmodule : memory_write_reply_and_read_cmd
